// ===== design/tsr_regs.svh
// Register offsets, reset values and field positions of the sensor block
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

// ==========================================================================
// Register offsets
`define TSR_A_LOCAL 8'h00
`define TSR_A_RMSB 8'h01
`define TSR_A_STATUS 8'h02
`define TSR_A_LHIGH 8'h05
`define TSR_A_LHIGH_ALT 8'h0b
`define TSR_A_RHIGH 8'h07
`define TSR_A_RHIGH_ALT 8'h0d
`define TSR_A_RLOW 8'h08
`define TSR_A_RLOW_ALT 8'h0e
`define TSR_A_RLSB 8'h10
`define TSR_A_TRIM_U 8'h11
`define TSR_A_TRIM_L 8'h12
`define TSR_A_RHIGH_F 8'h13
`define TSR_A_RLOW_F 8'h14
`define TSR_A_CRIT 8'h19
`define TSR_A_HYST 8'h21
`define TSR_A_CFG 8'hbf

// ==========================================================================
// Reset values
`define TSR_RST_LHIGH 8'h46
`define TSR_RST_RHIGH 8'h46
`define TSR_RST_RLOW 8'h00
`define TSR_RST_FRAC 3'h0
`define TSR_RST_TRIM 8'h00
`define TSR_RST_CRIT 8'h55
`define TSR_RST_HYST 8'h0a
`define TSR_RST_CFG 3'h0
`define TSR_RST_STATUS 8'h00

// ==========================================================================
// Field positions
`define TSR_CFG_CMP_BIT 0
`define TSR_ST_LHIGH 6
`define TSR_ST_RHIGH 4
`define TSR_ST_RLOW 3
`define TSR_ST_CRIT 1
`define TSR_NUM_FLAGS 4

`endif

// ===== design/tsr_pkg.sv
// Types shared by the temperature setpoint register block
package tsr_pkg;

	// Register access request from the serial bus engine
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tsr_req_s;

	// One converter result: local integer and remote with three fractions
	typedef struct packed {
		logic valid;
		logic [7:0] local_t;
		logic [10:0] remote_t;
	} tsr_conv_s;

	typedef logic signed [10:0] tsr_temp_t;

	typedef enum logic [1:0] {
		TSR_FILT_OFF = 2'h0,
		TSR_FILT_MIN_A = 2'h1,
		TSR_FILT_MIN_B = 2'h2,
		TSR_FILT_MAX = 2'h3
	} tsr_filt_e;

endpackage

// ===== design/tsr_filter.sv
// Remote reading smoothing filter with three strengths
`timescale 1ns/100ps
module tsr_filter #(
	parameter int W = 11
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Setting
	input wire tsr_pkg::tsr_filt_e level,
	// Sample in
	input wire logic in_valid,
	input wire logic signed [W-1:0] in_val,
	// Sample out
	output logic out_valid,
	output logic signed [W-1:0] out_val
);
	import tsr_pkg::*;

	logic primed_r;
	logic signed [W+1:0] prev_x;
	logic signed [W+1:0] new_x;
	logic signed [W+1:0] avg_min;
	logic signed [W+1:0] avg_max;
	logic signed [W-1:0] filt_nxt;

	assign prev_x = {{2{out_val[W-1]}}, out_val};
	assign new_x = {{2{in_val[W-1]}}, in_val};
	assign avg_min = (prev_x + new_x) >>> 1;
	assign avg_max = (prev_x + prev_x + prev_x + new_x) >>> 2;
	// Both middle codes give the same light filtering
	assign filt_nxt = (level == TSR_FILT_OFF || !primed_r) ? in_val :
		(level == TSR_FILT_MAX) ? avg_max[W-1:0] : avg_min[W-1:0];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			primed_r <= 1'b0;
			out_valid <= 1'b0;
			out_val <= '0;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				primed_r <= 1'b1;
				out_val <= filt_nxt;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_filter_bypass: assert property (in_valid && level == TSR_FILT_OFF
		|=> out_valid && out_val == $past(in_val))
		else $error("unfiltered sample not passed straight through");

endmodule // tsr_filter

// ===== design/tsr_window.sv
// Signed window comparator: above the high limit, below the low limit
`timescale 1ns/100ps
module tsr_window #(
	parameter int W = 11
) (
	// Value and limits
	input wire logic signed [W-1:0] value,
	input wire logic signed [W-1:0] high_lim,
	input wire logic signed [W-1:0] low_lim,
	// Results
	output logic above,
	output logic below
);
	assign above = value > high_lim;
	assign below = value < low_lim;
endmodule // tsr_window

// ===== design/tsr_sensor_regs.sv
// Register side of the local and remote temperature sensor
// Notes on behaviour
// - Local temperature reads at 00 as read-only byte; reads zero before the first conversion.
// - Local high limit at 05, also 0B, read-write, resets to 46 hex.
// - Remote upper byte is two's complement, sign bit 7, one degree bit 0.
// - Remote fraction byte holds half, quarter, eighth in 7:5; 4:0 zero.
// - Stored remote value is reported as trimmed, without the fixed shift.
// - Signed trim from 11 and 12 is added to each remote result, not local; resets zero.
// - Remote high limit: upper at 07 or 0D, resets 46; fraction at 13.
// - Remote low limit: upper at 08 or 0E, resets zero; fraction at 14.
// - Critical limit at 19 is a byte resetting to 55 hex, always writable.
// - Critical stays set until remote drops below limit minus hysteresis at 21.
// - Filter field at BF: off, light, light, strong; resets to off.
// - BF bit 0 set: alert follows condition; clear: latched until alert response.
// - Remote high alarm above high limit, remote low alarm below low limit.
// - Local high alarm when local temperature strictly above its limit.
// - Alarm flags latch until status read, then clear only if condition gone.
`timescale 1ns/100ps
`include "tsr_regs.svh"
module tsr_sensor_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register access from the serial bus engine
	input wire tsr_pkg::tsr_req_s req,
	input wire logic ara_ack,
	output logic [7:0] rdata,
	output logic rvalid,
	// Converter results
	input wire tsr_pkg::tsr_conv_s conv,
	// Open-drain pins, pulled low while enabled
	output logic alert_oe,
	output logic crit_oe
);
	import tsr_pkg::*;

	// ======================================================================
	// Decoding
	function automatic logic hit(input logic [7:0] a, input logic [7:0] p,
		input logic [7:0] q);
		hit = (a == p) || (a == q);
	endfunction

	logic [7:0] local_r;
	tsr_temp_t remote_r;
	tsr_temp_t adj_r;
	logic adj_valid_r;
	logic [7:0] lhigh_r;
	logic [7:0] rhigh_r;
	logic [7:0] rlow_r;
	logic [2:0] rhigh_f_r;
	logic [2:0] rlow_f_r;
	logic [7:0] trim_u_r;
	logic [2:0] trim_l_r;
	logic [7:0] crit_lim_r;
	logic [7:0] hyst_r;
	logic [2:0] cfg_r;
	logic [2:0] frac_snap_r;
	logic cmp_en_r;
	logic crit_r;
	logic cond_r [`TSR_NUM_FLAGS];
	logic flag_r [`TSR_NUM_FLAGS];
	logic ev_r;
	logic int_r;
	logic [7:0] rd_mux;

	wire wr_lhigh = req.wr && hit(req.addr, `TSR_A_LHIGH, `TSR_A_LHIGH_ALT);
	wire wr_rhigh = req.wr && hit(req.addr, `TSR_A_RHIGH, `TSR_A_RHIGH_ALT);
	wire wr_rlow = req.wr && hit(req.addr, `TSR_A_RLOW, `TSR_A_RLOW_ALT);
	wire wr_rhigh_f = req.wr && hit(req.addr, `TSR_A_RHIGH_F, `TSR_A_RHIGH_F);
	wire wr_rlow_f = req.wr && hit(req.addr, `TSR_A_RLOW_F, `TSR_A_RLOW_F);
	wire wr_trim_u = req.wr && hit(req.addr, `TSR_A_TRIM_U, `TSR_A_TRIM_U);
	wire wr_trim_l = req.wr && hit(req.addr, `TSR_A_TRIM_L, `TSR_A_TRIM_L);
	wire wr_crit = req.wr && hit(req.addr, `TSR_A_CRIT, `TSR_A_CRIT);
	wire wr_hyst = req.wr && hit(req.addr, `TSR_A_HYST, `TSR_A_HYST);
	wire wr_cfg = req.wr && hit(req.addr, `TSR_A_CFG, `TSR_A_CFG);
	wire rd_msb = req.rd && hit(req.addr, `TSR_A_RMSB, `TSR_A_RMSB);
	wire rd_clr = req.rd && hit(req.addr, `TSR_A_STATUS, `TSR_A_STATUS);

	// ======================================================================
	// Trim, saturation and filtering of the remote result
	wire tsr_temp_t trim = {trim_u_r, trim_l_r};
	wire logic signed [11:0] sum = {conv.remote_t[10], conv.remote_t}
		+ {trim[10], trim};
	wire sat_hi = !sum[11] && sum[10];
	wire sat_lo = sum[11] && !sum[10];
	wire tsr_temp_t adj_nxt = sat_hi ? 11'h3ff : sat_lo ? 11'h400 :
		sum[10:0];
	wire tsr_filt_e filt_level = tsr_filt_e'(cfg_r[2:1]);
	wire filt_valid;
	wire tsr_temp_t filt_val;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			adj_r <= '0;
			adj_valid_r <= 1'b0;
		end else begin
			adj_valid_r <= conv.valid;
			if (conv.valid)
				adj_r <= adj_nxt;
		end
	end

	tsr_filter #(
		.W(11)
	) u_filter (
		.clk(clk),
		.rst_n(rst_n),
		.level(filt_level),
		.in_valid(adj_valid_r),
		.in_val(adj_r),
		.out_valid(filt_valid),
		.out_val(filt_val)
	);

	// ======================================================================
	// Stored readings
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			local_r <= '0;
			remote_r <= '0;
			cmp_en_r <= 1'b0;
			frac_snap_r <= '0;
		end else begin
			if (conv.valid)
				local_r <= conv.local_t;
			if (filt_valid)
				remote_r <= filt_val;
			cmp_en_r <= filt_valid;
			if (rd_msb)
				frac_snap_r <= remote_r[2:0];
		end
	end

	// ======================================================================
	// Limit registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lhigh_r <= `TSR_RST_LHIGH;
			rhigh_r <= `TSR_RST_RHIGH;
			rlow_r <= `TSR_RST_RLOW;
			rhigh_f_r <= `TSR_RST_FRAC;
			rlow_f_r <= `TSR_RST_FRAC;
		end else begin
			if (wr_lhigh)
				lhigh_r <= req.wdata;
			if (wr_rhigh)
				rhigh_r <= req.wdata;
			if (wr_rlow)
				rlow_r <= req.wdata;
			if (wr_rhigh_f)
				rhigh_f_r <= req.wdata[7:5];
			if (wr_rlow_f)
				rlow_f_r <= req.wdata[7:5];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trim_u_r <= `TSR_RST_TRIM;
			trim_l_r <= `TSR_RST_FRAC;
			crit_lim_r <= `TSR_RST_CRIT;
			hyst_r <= `TSR_RST_HYST;
			cfg_r <= `TSR_RST_CFG;
		end else begin
			if (wr_trim_u)
				trim_u_r <= req.wdata;
			if (wr_trim_l)
				trim_l_r <= req.wdata[7:5];
			if (wr_crit)
				crit_lim_r <= req.wdata;
			if (wr_hyst)
				hyst_r <= req.wdata;
			if (wr_cfg)
				cfg_r <= req.wdata[2:0];
		end
	end

	// ======================================================================
	// Comparisons against the limits
	wire r_above;
	wire r_below;
	wire l_above;

	tsr_window #(
		.W(11)
	) u_remote_win (
		.value(remote_r),
		.high_lim({rhigh_r, rhigh_f_r}),
		.low_lim({rlow_r, rlow_f_r}),
		.above(r_above),
		.below(r_below)
	);

	tsr_window #(
		.W(8)
	) u_local_win (
		.value(local_r),
		.high_lim(lhigh_r),
		.low_lim(8'h80),
		.above(l_above),
		.below()
	);

	// Critical compare on whole degrees, widened so limit minus hysteresis
	// cannot wrap
	wire logic signed [8:0] rem_int = {remote_r[10], remote_r[10:3]};
	wire logic signed [8:0] crit_x = {crit_lim_r[7], crit_lim_r};
	wire logic signed [9:0] crit_low = {crit_x[8], crit_x} - {2'b00, hyst_r};
	wire crit_above = rem_int > crit_x;
	wire crit_below = rem_int < crit_low;
	wire crit_nxt = cmp_en_r ? (crit_above || (crit_r && !crit_below)) :
		crit_r;

	always_ff @(posedge clk) begin
		if (!rst_n)
			crit_r <= 1'b0;
		else
			crit_r <= crit_nxt;
	end

	// ======================================================================
	// Alarm conditions and sticky status flags
	wire cond_now [`TSR_NUM_FLAGS];
	assign cond_now[0] = l_above;
	assign cond_now[1] = r_above;
	assign cond_now[2] = r_below;
	assign cond_now[3] = crit_nxt;
	wire cond_any = cond_r[0] || cond_r[1] || cond_r[2] || cond_r[3];

	generate
		for (genvar i = 0; i < `TSR_NUM_FLAGS; i++) begin : g_flag
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					cond_r[i] <= 1'b0;
					flag_r[i] <= 1'b0;
				end else begin
					if (cmp_en_r)
						cond_r[i] <= cond_now[i];
					// A live condition beats the read clear
					flag_r[i] <= (flag_r[i] && !rd_clr) || cond_r[i];
				end
			end
		end
	endgenerate

	// ======================================================================
	// Alert pin: comparator or latched interrupt
	wire ev_nxt = cmp_en_r && (cond_now[0] || cond_now[1] ||
		cond_now[2] || cond_now[3]);
	wire int_nxt = (int_r && !ara_ack) || ev_r;
	wire cmp_mode = cfg_r[`TSR_CFG_CMP_BIT];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ev_r <= 1'b0;
			int_r <= 1'b0;
			alert_oe <= 1'b0;
			crit_oe <= 1'b0;
		end else begin
			ev_r <= ev_nxt;
			int_r <= int_nxt;
			alert_oe <= cmp_mode ? cond_any : int_nxt;
			crit_oe <= crit_nxt;
		end
	end

	// ======================================================================
	// Read data
	wire [7:0] status = {1'b0, flag_r[0], 1'b0, flag_r[1], flag_r[2],
		1'b0, flag_r[3], 1'b0};

	always_comb begin
		case (req.addr)
			`TSR_A_LOCAL: rd_mux = local_r;
			`TSR_A_RMSB: rd_mux = remote_r[10:3];
			`TSR_A_STATUS: rd_mux = status;
			`TSR_A_LHIGH, `TSR_A_LHIGH_ALT: rd_mux = lhigh_r;
			`TSR_A_RHIGH, `TSR_A_RHIGH_ALT: rd_mux = rhigh_r;
			`TSR_A_RLOW, `TSR_A_RLOW_ALT: rd_mux = rlow_r;
			`TSR_A_RLSB: rd_mux = {frac_snap_r, 5'h00};
			`TSR_A_TRIM_U: rd_mux = trim_u_r;
			`TSR_A_TRIM_L: rd_mux = {trim_l_r, 5'h00};
			`TSR_A_RHIGH_F: rd_mux = {rhigh_f_r, 5'h00};
			`TSR_A_RLOW_F: rd_mux = {rlow_f_r, 5'h00};
			`TSR_A_CRIT: rd_mux = crit_lim_r;
			`TSR_A_HYST: rd_mux = hyst_r;
			`TSR_A_CFG: rd_mux = {5'h00, cfg_r};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			if (req.rd)
				rdata <= rd_mux;
		end
	end

	// ======================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_high_seen;
		cmp_en_r && r_above;
	endsequence

	sequence s_high_flagged;
		cond_r[1] ##1 flag_r[1];
	endsequence

	chk_local_read: assert property (
		req.rd && req.addr == `TSR_A_LOCAL |=> rvalid && rdata == $past(local_r))
		else $error("local reading not returned");
	chk_alt_lhigh: assert property (
		req.wr && req.addr == `TSR_A_LHIGH_ALT
		|=> lhigh_r == $past(req.wdata) ##1 rd_mux == lhigh_r
			|| req.addr != `TSR_A_LHIGH)
		else $error("alternate local limit address not shared");
	chk_frac_zero: assert property (
		rvalid && $past(req.addr) == `TSR_A_RLSB |-> rdata[4:0] == 5'h00)
		else $error("fraction low bits not zero");
	chk_trim_sum: assert property (
		conv.valid && !sat_hi && !sat_lo |=> adj_r == $past(sum[10:0]))
		else $error("trim not added to result");
	chk_crit_hold: assert property (
		crit_r && !(cmp_en_r && crit_below) |=> crit_r)
		else $error("critical released above threshold");
	chk_flag_sticky: assert property (
		flag_r[1] && !rd_clr |=> flag_r[1])
		else $error("alarm flag dropped without status read");
	chk_cmp_mode: assert property (
		cmp_mode |=> alert_oe == $past(cond_any))
		else $error("comparator alert not following condition");
	chk_ara_clear: assert property (
		!cmp_mode && ara_ack && !ev_r ##1 !cmp_mode |-> !alert_oe)
		else $error("alert not released by alert response");
	chk_high_alarm: assert property (
		s_high_seen |=> s_high_flagged)
		else $error("remote high alarm not flagged");
	chk_crit_reset: assert property (
		$rose(rst_n) |-> crit_lim_r == `TSR_RST_CRIT)
		else $error("critical limit reset value wrong");

endmodule // tsr_sensor_regs

// ===== verif/tsr_host_model.sv
// Register-port host model issuing single reads and writes
`timescale 1ns/100ps
`include "tsr_regs.svh"
module tsr_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output tsr_pkg::tsr_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	import tsr_pkg::*;

	initial req = '0;

	// ==========================================================================
	// Access tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		req.addr = a;
		req.wdata = (a == `TSR_A_CFG) ? {5'h00, d[2:0]} : d;
		req.wr = 1'b1;
		@(posedge clk);
		#1;
		req.wr = 1'b0;
		// Released lines show a changed value, not the old one
		req.addr = ~a;
		req.wdata = ~req.wdata;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		req.addr = a;
		req.rd = 1'b1;
		@(posedge clk);
		#1;
		req.rd = 1'b0;
		req.addr = ~a;
		// Read data must answer exactly one cycle after the request
		d = (rvalid === 1'b1) ? rdata : 8'hxx;
	endtask

	// Upper byte first so the fraction snapshot matches it
	task automatic rd_remote(output logic [7:0] hi, output logic [7:0] lo);
		rd(`TSR_A_RMSB, hi);
		rd(`TSR_A_RLSB, lo);
	endtask
endmodule // tsr_host_model

// ===== verif/tsr_sensor_regs_tb_top.sv
// Self-checking bench for the sensor register block
`timescale 1ns/100ps
`include "tsr_regs.svh"
module tsr_sensor_regs_tb_top;
	import tsr_pkg::*;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ara_ack = 1'b0;
	tsr_req_s req;
	tsr_conv_s conv = '0;
	logic [7:0] rdata;
	logic rvalid;
	logic alert_oe;
	logic crit_oe;
	logic [7:0] d;
	int fails = 0;
	int checked = 0;
	logic [7:0] ra [15] = '{8'h05, 8'h0b, 8'h07, 8'h0d, 8'h08, 8'h0e, 8'h13,
		8'h14, 8'h11, 8'h12, 8'h19, 8'h21, 8'hbf, 8'h02, 8'h03};
	logic [7:0] rv [15] = '{8'h46, 8'h46, 8'h46, 8'h46, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h55, 8'h0a, 8'h00, 8'h00, 8'h00};
	logic [1:0] fl [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	logic [7:0] fin [4] = '{8'h10, 8'h12, 8'h13, 8'h14};
	logic [7:0] fh [4] = '{8'h10, 8'h11, 8'h12, 8'h12};
	logic [7:0] ff [4] = '{8'h00, 8'h00, 8'h00, 8'h80};

	always #12.5 clk = ~clk;

	tsr_sensor_regs dut (.clk(clk), .rst_n(rst_n), .req(req),
		.ara_ack(ara_ack), .rdata(rdata), .rvalid(rvalid), .conv(conv),
		.alert_oe(alert_oe), .crit_oe(crit_oe));
	tsr_host_model host (.clk(clk), .req(req), .rdata(rdata),
		.rvalid(rvalid));

	// ==========================================================================
	// Helpers
	task automatic ck(input string n, input logic [7:0] e,
		input logic [7:0] s);
		checked++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		host.rd(a, v);
		ck($sformatf("reg %h", a), e, v);
	endtask

	task automatic rr(input logic [7:0] h, input logic [7:0] l);
		logic [7:0] a;
		logic [7:0] b;
		host.rd_remote(a, b);
		ck("remote upper", h, a);
		ck("remote fraction", l, b);
	endtask

	// One converter result, then time for the whole alarm path
	task automatic cv(input logic [7:0] l, input logic [10:0] r);
		@(posedge clk);
		#1;
		conv = '{1'b1, l, r};
		@(posedge clk);
		#1;
		conv.valid = 1'b0;
		repeat (7) @(posedge clk);
		#1;
	endtask

	task automatic ara;
		@(posedge clk);
		#1;
		ara_ack = 1'b1;
		@(posedge clk);
		#1;
		ara_ack = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==========================================================================
	// Tests
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		ck("alert pin", 8'h00, {7'h00, alert_oe});
		foreach (ra[i]) rc(ra[i], rv[i]);
		$display("test reset values done");

		host.wr(8'h0b, 8'h5a);
		rc(8'h05, 8'h5a);
		host.wr(8'h0d, 8'h50);
		rc(8'h07, 8'h50);
		host.wr(8'h07, 8'h46);
		host.wr(8'h0e, 8'hf6);
		rc(8'h08, 8'hf6);
		host.wr(8'h13, 8'hff);
		rc(8'h13, 8'he0);
		host.wr(8'h00, 8'h33);
		rc(8'h00, 8'h00);
		host.wr(8'h05, 8'h46);
		host.wr(8'h08, 8'h00);
		host.wr(8'h13, 8'h00);
		$display("test write and alias done");

		host.wr(8'hbf, 8'h01);
		cv(8'h20, {8'h19, 3'h5});
		rc(8'h00, 8'h20);
		rr(8'h19, 8'ha0);
		host.wr(8'h11, 8'h02);
		host.wr(8'h12, 8'h9f);
		rc(8'h12, 8'h80);
		cv(8'h20, {8'h19, 3'h5});
		rr(8'h1c, 8'h20);
		host.wr(8'h11, 8'h00);
		host.wr(8'h12, 8'h00);
		cv(8'h20, {8'hfe, 3'h6});
		rr(8'hfe, 8'hc0);
		foreach (fl[i]) begin
			host.wr(8'hbf, {5'h00, fl[i], 1'b1});
			cv(8'h20, {fin[i], 3'h0});
			rr(fh[i], ff[i]);
		end
		host.wr(8'hbf, 8'h01);
		$display("test conversion done");

		rc(8'h02, 8'h08);
		rc(8'h02, 8'h00);
		cv(8'h46, {8'h20, 3'h0});
		rc(8'h02, 8'h00);
		cv(8'h47, {8'h20, 3'h0});
		ck("alert pin", 8'h01, {7'h00, alert_oe});
		rc(8'h02, 8'h40);
		cv(8'h20, {8'h46, 3'h1});
		rc(8'h02, 8'h50);
		rc(8'h02, 8'h10);
		cv(8'h20, {8'h46, 3'h0});
		rc(8'h02, 8'h10);
		rc(8'h02, 8'h00);
		ck("alert pin", 8'h00, {7'h00, alert_oe});
		cv(8'h20, {8'hff, 3'h7});
		cv(8'h20, {8'h20, 3'h0});
		rc(8'h02, 8'h08);
		rc(8'h02, 8'h00);
		$display("test alarms done");

		cv(8'h20, {8'h56, 3'h0});
		ck("crit pin", 8'h01, {7'h00, crit_oe});
		rc(8'h02, 8'h12);
		cv(8'h20, {8'h4b, 3'h0});
		ck("crit pin", 8'h01, {7'h00, crit_oe});
		cv(8'h20, {8'h4a, 3'h0});
		ck("crit pin", 8'h00, {7'h00, crit_oe});
		host.wr(8'h19, 8'h40);
		rc(8'h19, 8'h40);
		cv(8'h20, {8'h4a, 3'h0});
		ck("crit pin", 8'h01, {7'h00, crit_oe});
		host.wr(8'h19, 8'h55);
		$display("test critical done");

		host.wr(8'hbf, 8'h00);
		cv(8'h20, {8'h20, 3'h0});
		host.rd(8'h02, d);
		host.rd(8'h02, d);
		ara();
		ck("alert pin", 8'h00, {7'h00, alert_oe});
		cv(8'h47, {8'h20, 3'h0});
		cv(8'h20, {8'h20, 3'h0});
		ck("alert pin", 8'h01, {7'h00, alert_oe});
		ara();
		ck("alert pin", 8'h00, {7'h00, alert_oe});
		$display("test interrupt mode done");
		print_verdict();
	end

	// Tests need under a thousand cycles; four thousand means a hang
	initial begin
		repeat (4000) @(posedge clk);
		fails++;
		print_verdict();
	end
endmodule // tsr_sensor_regs_tb_top
